// ==== verilog/cbs_regs.svh ====
// constants for the bus cycle sequencer
`ifndef CBS_REGS_SVH
`define CBS_REGS_SVH
`define CBS_QUEUE_BYTES 4'h8
`define CBS_NMI_ADDR    24'hffff00
`define CBS_INT_ADDR    24'hfffe00
`define CBS_STAT_IDLE   4'h0
`define CBS_STAT_INTA   4'h4
`define CBS_STAT_INTAC  4'h5
`define CBS_STAT_EOI    4'h6
`define CBS_STAT_EOIC   4'h7
`define CBS_STAT_SEQ    4'h8
`define CBS_STAT_NSEQ   4'h9
`endif

// ==== verilog/cbs_pkg.sv ====
// types for the bus cycle sequencer
package cbs_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_T1   = 5'h02,
    ST_T2   = 5'h04,
    ST_T3   = 5'h08,
    ST_T4   = 5'h10
  } cbs_state_t;
  typedef enum logic [2:0] {
    K_SEQ  = 3'h0,
    K_NSEQ = 3'h1,
    K_NMI  = 3'h2,
    K_INTA = 3'h3,
    K_INTC = 3'h4,
    K_EOI  = 3'h5,
    K_EOIC = 3'h6
  } cbs_kind_t;
endpackage : cbs_pkg

// ==== verilog/cbs_queue.sv ====
// eight-byte instruction prefetch queue
`timescale 1ns/1ps
`include "cbs_regs.svh"
module cbs_queue
  import cbs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // fill side
  input  wire logic        flush_i,
  input  wire logic        wr_i,
  input  wire logic        wr_hi_only_i,
  input  wire logic [15:0] wr_data_i,
  // drain side
  input  wire logic        pop_i,
  output logic      [7:0]  byte_o,
  output logic             byte_valid_o,
  output logic      [3:0]  free_o
);
  logic [7:0] mem [0:7];
  logic [2:0] wr_ptr;
  logic [2:0] rd_ptr;
  logic [3:0] count;
  logic       do_pop;
  logic [3:0] n_wr;

  assign do_pop = pop_i && (count != 4'h0);
  assign n_wr   = wr_i ? (wr_hi_only_i ? 4'h1 : 4'h2) : 4'h0;
  assign free_o = `CBS_QUEUE_BYTES - count;

  // low byte first, odd fetch carries only the high lane
  always_ff @(posedge clk_sys_i) begin
    if (wr_i && !flush_i) begin
      if (wr_hi_only_i) begin
        mem[wr_ptr] <= wr_data_i[15:8];
      end else begin
        mem[wr_ptr]        <= wr_data_i[7:0];
        mem[wr_ptr + 3'h1] <= wr_data_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      count  <= 4'h0;
    end else if (flush_i) begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      count  <= 4'h0;
    end else begin
      wr_ptr <= wr_ptr + n_wr[2:0];
      rd_ptr <= rd_ptr + {2'h0, do_pop};
      count  <= count + n_wr - {3'h0, do_pop};
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      byte_o       <= 8'h00;
      byte_valid_o <= 1'b0;
    end else begin
      byte_valid_o <= do_pop && !flush_i;
      if (do_pop) begin
        byte_o <= mem[rd_ptr];
      end
    end
  end

  // never written past its eight bytes
  queue_room_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    count <= `CBS_QUEUE_BYTES)
    else $error("queue overfilled");
endmodule : cbs_queue

// ==== verilog/cbs_seq.sv ====
// bus cycle sequencer: wait states, prefetch, interrupt control
//
// Contract
// - every cycle kind issued here may be lengthened by wait states.
// - wait input sampled at end of T2 on the rising clock edge; the code acts on the pin level taken at the edge that starts T1.
// - a wait state repeats T3 with bus controls held unchanged.
// - sampled active adds one wait and resamples; inactive ends cycle.
// - prefetched bytes enter the next free slot of an 8-byte queue.
// - sequential prefetch whenever the bus is idle and queue has room.
// - sequential prefetch is an even-address word read, both lanes on.
// - after flush or flow break, next fetch carries non-sequential status.
// - only first fetch is non-sequential; even word or odd high byte.
// - nmi, maskable interrupt or vectored return-from-interrupt run control cycles.
// - control cycles use read timing, differ only in status code; here nmi and interrupt acknowledge share status 0100 and differ in address.
// - each interrupt control cycle reads a single byte.
// - even cascade address: high byte enable off, vector on lanes 0-7.
// - odd cascade address: high byte enable on, vector on lanes 8-15.
// - sequential fetch presents status 1000, first status bit lowest.
// - first fetch after a purge presents status 1001.
// - unextended cycle is four clocks T1 to T4; others are idle.
`timescale 1ns/1ps
`include "cbs_regs.svh"
module cbs_seq
  import cbs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // bus pins
  input  wire logic        continuous_wait_n_i,
  input  wire logic [15:0] data_i,
  output logic      [23:0] address_o,
  output logic      [3:0]  bus_status_code_o,
  output logic             high_byte_enable_n_o,
  output logic             data_direction_in_n_o,
  output logic             addr_strobe_n_o,
  output logic             read_strobe_n_o,
  // core instruction side
  input  wire logic        flush_i,
  input  wire logic [23:0] target_i,
  input  wire logic        pop_i,
  output logic      [7:0]  byte_o,
  output logic             byte_valid_o,
  // core interrupt side
  input  wire logic        nmi_i,
  input  wire logic        int_i,
  input  wire logic        return_from_interrupt_op_i,
  input  wire logic        vectored_i,
  input  wire logic        cascaded_i,
  input  wire logic [23:0] cascade_addr_i,
  output logic      [7:0]  vector_o,
  output logic             int_done_o
);
  cbs_state_t state;
  cbs_state_t next_state;
  cbs_kind_t  kind;
  cbs_kind_t  next_kind;
  cbs_kind_t  casc_kind;
  logic [23:0] next_addr;
  logic        next_hbe_n;
  logic [23:0] fetch_addr;
  logic [1:0]  wait_sync;
  logic [15:0] data_s1;
  logic [15:0] data_s2;
  logic        wait_hold;
  logic        cap1;
  logic        cap2;
  logic        nseq_pend;
  logic        nmi_pend;
  logic        int_pend;
  logic        return_from_interrupt_op_pend;
  logic        casc_pend;
  logic        discard;
  logic        launch;
  logic        q_wr;
  logic [3:0]  q_free;
  logic [7:0]  lane_byte;

  function automatic logic [3:0] status_of(input cbs_kind_t k);
    unique case (k)
      K_SEQ:   status_of = `CBS_STAT_SEQ;
      K_NSEQ:  status_of = `CBS_STAT_NSEQ;
      K_NMI:   status_of = `CBS_STAT_INTA;
      K_INTA:  status_of = `CBS_STAT_INTA;
      K_INTC:  status_of = `CBS_STAT_INTAC;
      K_EOI:   status_of = `CBS_STAT_EOI;
      K_EOIC:  status_of = `CBS_STAT_EOIC;
      default: status_of = `CBS_STAT_IDLE;
    endcase
  endfunction : status_of

  function automatic logic is_fetch(input cbs_kind_t k);
    is_fetch = (k == K_SEQ) || (k == K_NSEQ);
  endfunction : is_fetch

  // pins pass two flops; wait is therefore seen two clocks late
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wait_sync <= 2'h3;
      data_s1   <= 16'h0000;
      data_s2   <= 16'h0000;
    end else begin
      wait_sync <= {wait_sync[0], continuous_wait_n_i};
      data_s1   <= data_i;
      data_s2   <= data_s1;
    end
  end

  // issue: cascade step, nmi, int, return, then fetches
  always_comb begin
    next_state = state;
    next_kind  = kind;
    next_addr  = address_o;
    next_hbe_n = high_byte_enable_n_o;
    launch     = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (!cap1 && !cap2) begin
          launch     = 1'b1;
          next_hbe_n = 1'b1;
          if (casc_pend) begin
            next_kind  = casc_kind;
            next_addr  = cascade_addr_i;
            next_hbe_n = ~cascade_addr_i[0];
          end else if (nmi_pend) begin
            next_kind = K_NMI;
            next_addr = `CBS_NMI_ADDR;
          end else if (int_pend) begin
            next_kind = K_INTA;
            next_addr = `CBS_INT_ADDR;
          end else if (return_from_interrupt_op_pend) begin
            next_kind = K_EOI;
            next_addr = `CBS_INT_ADDR;
          end else if (nseq_pend &&
                       (q_free >= (fetch_addr[0] ? 4'h1 : 4'h2))) begin
            next_kind  = K_NSEQ;
            next_addr  = fetch_addr;
            next_hbe_n = 1'b0;
          end else if (!nseq_pend && q_free >= 4'h2) begin
            next_kind  = K_SEQ;
            next_addr  = fetch_addr;
            next_hbe_n = 1'b0;
          end else begin
            launch = 1'b0;
          end
        end
        if (launch) begin
          next_state = ST_T1;
        end
      end
      ST_T1: next_state = ST_T2;
      ST_T2: next_state = ST_T3;
      ST_T3: begin
        // every kind here is extendable
        if (!wait_hold) begin
          next_state = ST_T4;
        end
      end
      ST_T4: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state     <= ST_IDLE;
      kind      <= K_SEQ;
      wait_hold <= 1'b0;
    end else begin
      state     <= next_state;
      kind      <= next_kind;
      // sampled at end of T2, resampled each T3
      wait_hold <= (state == ST_T2 || state == ST_T3) && !wait_sync[1];
    end
  end

  // bus outputs flat through T3 since only T1 loads them
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      address_o             <= 24'h000000;
      bus_status_code_o     <= `CBS_STAT_IDLE;
      high_byte_enable_n_o  <= 1'b1;
      data_direction_in_n_o <= 1'b1;
      addr_strobe_n_o       <= 1'b1;
      read_strobe_n_o       <= 1'b1;
    end else begin
      address_o             <= next_addr;
      high_byte_enable_n_o  <= next_hbe_n;
      bus_status_code_o     <= (next_state == ST_IDLE) ? `CBS_STAT_IDLE
                                                       : status_of(next_kind);
      data_direction_in_n_o <= (next_state == ST_IDLE);
      addr_strobe_n_o       <= (next_state != ST_T1);
      read_strobe_n_o       <= !(next_state == ST_T2 || next_state == ST_T3);
    end
  end

  // data taken two clocks after T4 begins, matching the sync delay
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cap1 <= 1'b0;
      cap2 <= 1'b0;
    end else begin
      cap1 <= (state == ST_T3) && !wait_hold;
      cap2 <= cap1;
    end
  end

  // fetch address and non-sequential mark; flush wins over launch
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      fetch_addr <= 24'h000000;
      nseq_pend  <= 1'b1;
      discard    <= 1'b0;
    end else begin
      if (flush_i) begin
        fetch_addr <= target_i;
        nseq_pend  <= 1'b1;
        discard    <= 1'b1;
      end else begin
        if (launch && is_fetch(next_kind)) begin
          fetch_addr <= fetch_addr + (fetch_addr[0] ? 24'h1 : 24'h2);
        end
        if (launch && next_kind == K_NSEQ) begin
          nseq_pend <= 1'b0;
        end
        if (launch) begin
          discard <= 1'b0;
        end
      end
    end
  end

  // request flags: a new request beats the clear on launch
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      nmi_pend  <= 1'b0;
      int_pend  <= 1'b0;
      return_from_interrupt_op_pend <= 1'b0;
    end else begin
      nmi_pend  <= nmi_i || (nmi_pend && !(launch && next_kind == K_NMI));
      int_pend  <= int_i || (int_pend && !(launch && next_kind == K_INTA));
      // non-vectored return needs no bus cycle
      return_from_interrupt_op_pend <= (return_from_interrupt_op_i && vectored_i) ||
                   (return_from_interrupt_op_pend && !(launch && next_kind == K_EOI));
    end
  end

  assign lane_byte = address_o[0] ? data_s2[15:8] : data_s2[7:0];
  assign q_wr      = cap2 && is_fetch(kind) && !discard;

  // completion: cascade second step, vector, done pulse
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      casc_pend  <= 1'b0;
      casc_kind  <= K_INTC;
      vector_o   <= 8'h00;
      int_done_o <= 1'b0;
    end else begin
      int_done_o <= return_from_interrupt_op_i && !vectored_i;
      if (launch && casc_pend) begin
        casc_pend <= 1'b0;
      end
      if (cap2) begin
        unique case (kind)
          K_INTA, K_EOI: begin
            if (vectored_i && cascaded_i) begin
              casc_pend <= 1'b1;
              casc_kind <= (kind == K_INTA) ? K_INTC : K_EOIC;
            end else begin
              int_done_o <= 1'b1;
            end
            if (kind == K_INTA) begin
              vector_o <= data_s2[7:0];
            end
          end
          K_INTC: begin
            vector_o   <= lane_byte;
            int_done_o <= 1'b1;
          end
          K_NMI, K_EOIC: int_done_o <= 1'b1;
          K_SEQ, K_NSEQ: ;
          default: ;
        endcase
      end
    end
  end

  cbs_queue u_queue (
    .clk_sys_i    (clk_sys_i),
    .reset_i      (reset_i),
    .flush_i      (flush_i),
    .wr_i         (q_wr),
    .wr_hi_only_i (address_o[0]),
    .wr_data_i    (data_s2),
    .pop_i        (pop_i),
    .byte_o       (byte_o),
    .byte_valid_o (byte_valid_o),
    .free_o       (q_free)
  );

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence s_run;
    state == ST_T1 ##1 state == ST_T2 ##1 state == ST_T3;
  endsequence

  cycle_shape_a: assert property (
    state == ST_IDLE && next_state == ST_T1 |=> s_run)
    else $error("cycle did not run T1 T2 T3");
  wait_repeat_a: assert property (
    state == ST_T3 && wait_hold |=> state == ST_T3)
    else $error("wait state not inserted");
  wait_sample_a: assert property (
    state == ST_T2 && wait_sync[1] |=> state == ST_T3 ##1 state == ST_T4)
    else $error("inactive wait did not finish cycle");
  t3_flat_a: assert property (
    state == ST_T3 && $past(state) == ST_T3 |->
      $stable(address_o) && $stable(read_strobe_n_o) &&
      $stable(bus_status_code_o) && $stable(high_byte_enable_n_o))
    else $error("controls moved during wait");
  seq_word_a: assert property (
    !addr_strobe_n_o && bus_status_code_o == `CBS_STAT_SEQ |->
      !address_o[0] && !high_byte_enable_n_o)
    else $error("sequential fetch not even word");
  nseq_first_a: assert property (
    launch && nseq_pend && is_fetch(next_kind) |=>
      bus_status_code_o == `CBS_STAT_NSEQ)
    else $error("flow break fetch not non-sequential");
  icu_byte_a: assert property (
    !addr_strobe_n_o && bus_status_code_o[3:2] == 2'h1 |->
      high_byte_enable_n_o != address_o[0])
    else $error("control cycle not single byte");
  nmi_addr_a: assert property (
    !addr_strobe_n_o && address_o == `CBS_NMI_ADDR |->
      bus_status_code_o == `CBS_STAT_INTA && !data_direction_in_n_o)
    else $error("nmi acknowledge malformed");
  room_fetch_a: assert property (
    launch && next_kind == K_SEQ |-> q_free >= 4'h2)
    else $error("fetch issued without room");
endmodule : cbs_seq

// ==== tb/cbs_mem_model.sv ====
// memory and interrupt unit model on the far side of the bus
`timescale 1ns/1ps
module cbs_mem_model (
  // clock
  input  wire logic        clk_sys_i,
  // bus from the sequencer, plus wait length from the bench
  input  wire logic [23:0] addr_i,
  input  wire logic        ads_n_i,
  input  wire logic        rd_n_i,
  input  wire logic [3:0]  wait_len_i,
  // answers
  output logic      [15:0] data_o,
  output logic             wait_n_o
);
  logic [3:0] cnt = 4'h0;

  // released bus toggles so stale data never looks valid
  always @(negedge clk_sys_i) begin
    if (!rd_n_i) data_o <= {addr_i[7:0] ^ 8'ha5, addr_i[7:0] ^ 8'h3c};
    else data_o <= ~data_o;
  end

  // wait pin is synchronised inside, so it must lead the cycle:
  // low from idle through one edge per extra T3, counted from T1
  always @(negedge clk_sys_i) begin
    if (!ads_n_i || !rd_n_i) begin
      if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end else begin
      cnt <= wait_len_i;
    end
  end

  assign wait_n_o = (cnt == 4'h0);
endmodule : cbs_mem_model

// ==== tb/tb_cpu_bus_cycle_sequencer.sv ====
// self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
module tb_cpu_bus_cycle_sequencer;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        flush = 1'b0, pop = 1'b0, nmi = 1'b0, intr = 1'b0;
  logic        ret = 1'b0, vect = 1'b0, casc = 1'b0;
  logic [23:0] target = 24'h0, casc_addr = 24'h0;
  logic [3:0]  wlen = 4'h0;
  wire         wait_n;
  wire  [15:0] data;
  logic [23:0] addr;
  logic [3:0]  st;
  logic        hbe_n, data_direction_in_n_n, ads_n, rd_n, bval, done;
  logic [7:0]  byte_q, vec, got_byte;
  logic [23:0] c_addr;
  logic [3:0]  c_st;
  logic        c_hbe;
  int          c_len, q_ads, q_done, l3;
  int          error_cnt = 0;
  int          cmp_count = 0;

  cbs_seq u_cbs_seq (.clk_sys_i(clk), .reset_i(rst),
    .continuous_wait_n_i(wait_n), .data_i(data), .address_o(addr),
    .bus_status_code_o(st), .high_byte_enable_n_o(hbe_n),
    .data_direction_in_n_o(data_direction_in_n_n), .addr_strobe_n_o(ads_n),
    .read_strobe_n_o(rd_n), .flush_i(flush), .target_i(target),
    .pop_i(pop), .byte_o(byte_q), .byte_valid_o(bval), .nmi_i(nmi),
    .int_i(intr), .return_from_interrupt_op_i(ret), .vectored_i(vect),
    .cascaded_i(casc), .cascade_addr_i(casc_addr), .vector_o(vec),
    .int_done_o(done));

  cbs_mem_model u_cbs_mem_model (.clk_sys_i(clk), .addr_i(addr),
    .ads_n_i(ads_n), .rd_n_i(rd_n), .wait_len_i(wlen), .data_o(data),
    .wait_n_o(wait_n));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // next negedge with all request pulses dropped
  task automatic step();
    @(negedge clk);
    {flush, pop, nmi, intr, ret} = 5'h0;
  endtask : step

  // follow one bus cycle from address strobe to end of read strobe
  task automatic grab();
    int n;
    n = 0;
    c_len = 0;
    step();
    while (n < 64 && ads_n !== 1'b0) begin
      step();
      n++;
    end
    chk(ads_n, 0);
    chk(data_direction_in_n_n, 0);
    {c_hbe, c_st, c_addr} = {hbe_n, st, addr};
    while (n < 64 && !(c_len > 0 && rd_n === 1'b1)) begin
      step();
      n++;
      if (rd_n === 1'b0) begin
        c_len++;
        chk({hbe_n, 3'h0, st, addr}, {c_hbe, 3'h0, c_st, c_addr});
      end
    end
  endtask : grab

  task automatic cyc(input logic [3:0] s, input logic [23:0] a,
                     input logic h);
    grab();
    chk({c_hbe, c_st, c_addr}, {h, s, a});
  endtask : cyc

  // watch for strobes and completion over n clocks
  task automatic quiet(input int n);
    q_ads = 0;
    q_done = 0;
    repeat (n) begin
      step();
      q_ads += (ads_n === 1'b0);
      q_done += (done === 1'b1);
    end
  endtask : quiet

  task automatic pop1();
    @(negedge clk);
    pop = 1'b1;
    got_byte = 8'h0;
    repeat (4) begin
      step();
      if (bval === 1'b1) got_byte = byte_q;
    end
  endtask : pop1

  task automatic t_boot();
    logic [15:0] w;
    cyc(4'h9, 24'h0, 1'b0);
    chk(c_len, 2);
    for (int i = 2; i < 8; i += 2) cyc(4'h8, 24'(i), 1'b0);
    quiet(40);
    chk(q_ads, 0);
    for (int i = 0; i < 8; i++) begin
      w = {i[7:0] & 8'hfe ^ 8'ha5, i[7:0] & 8'hfe ^ 8'h3c};
      pop1();
      chk(got_byte, i[0] ? w[15:8] : w[7:0]);
    end
    quiet(40);
  endtask : t_boot

  task automatic t_wait();
    wlen = 4'h3;
    @(negedge clk);
    pop = 1'b1;
    @(negedge clk);
    cyc(4'h8, 24'h10, 1'b0);
    l3 = c_len;
    wlen = 4'h5;
    @(negedge clk);
    pop = 1'b1;
    @(negedge clk);
    cyc(4'h8, 24'h12, 1'b0);
    chk(c_len - l3, 2);
    chk(l3 > 2, 1);
    wlen = 4'h0;
    quiet(20);
  endtask : t_wait

  task automatic t_flush();
    @(negedge clk);
    flush = 1'b1;
    target = 24'h101;
    cyc(4'h9, 24'h101, 1'b0);
    cyc(4'h8, 24'h102, 1'b0);
    quiet(40);
    pop1();
    chk(got_byte, 8'ha4);
    quiet(40);
  endtask : t_flush

  task automatic t_int();
    @(negedge clk);
    nmi = 1'b1;
    cyc(4'h4, 24'hffff00, 1'b1);
    quiet(8);
    chk(q_ads, 0);
    chk(q_done, 1);
    @(negedge clk);
    intr = 1'b1;
    cyc(4'h4, 24'hfffe00, 1'b1);
    quiet(8);
    chk(q_done, 1);
    chk(vec, 8'h3c);
    @(negedge clk);
    ret = 1'b1;
    quiet(8);
    chk(q_ads, 0);
    chk(q_done, 1);
    vect = 1'b1;
    for (int k = 0; k < 3; k++) begin
      casc = (k != 0);
      casc_addr = (k == 1) ? 24'h000a20 : 24'h000a21;
      @(negedge clk);
      intr = 1'b1;
      cyc(4'h4, 24'hfffe00, 1'b1);
      if (casc) cyc(4'h5, casc_addr, k == 1);
      quiet(8);
      chk(q_done, 1);
      chk(vec, k == 0 ? 8'h3c : k == 1 ? 8'h1c : 8'h84);
      @(negedge clk);
      ret = 1'b1;
      cyc(4'h6, 24'hfffe00, 1'b1);
      if (casc) cyc(4'h7, casc_addr, k == 1);
      quiet(8);
      chk(q_done, 1);
    end
  endtask : t_int

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // run takes well under 2000 clocks
  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_boot();
    t_wait();
    t_flush();
    t_int();
    tally_and_finish();
  end
endmodule : tb_cpu_bus_cycle_sequencer
